// ### rtl/trace_cmp_pkg.sv
// Purpose: shared constants and types for the trace count / compare c block
// Assumes: word-wide ahb-lite access, one register per aligned word
// Notes: byte address of a register is four times its index

package trace_cmp_pkg;

  // ==========================================================================
  // register indices (byte address = index * 4)
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h30;
  localparam logic [IDX_W-1:0] IDX_STAT = 8'h31;
  localparam logic [IDX_W-1:0] IDX_COUNT = 8'h24;
  localparam logic [IDX_W-1:0] IDX_PAGE_EXT = 8'h25;
  localparam logic [IDX_W-1:0] IDX_VAL_HI = 8'h26;
  localparam logic [IDX_W-1:0] IDX_VAL_LO = 8'h27;

  // ==========================================================================
  // field layout
  localparam int CTRL_ARM_BIT = 7;
  localparam int CTRL_BEGIN_BIT = 4;
  localparam int CTRL_BRK_BIT = 3;
  localparam int CTRL_CMP_BRK_BIT = 2;
  localparam int CAPMOD_LSB = 0;
  localparam int CAPMOD_MSB = 1;
  localparam logic [7:0] CTRL_STORE_MASK = 8'h1f;
  localparam logic [1:0] CAPMOD_LOOP_FILTER_CAPTURE = 2'h1;
  localparam int COUNT_FULL_BIT = 7;
  localparam int PAGING_TYPE_SELECT_PAGED_BIT = 6;
  localparam int EXT_CMP_MSB = 5;
  localparam int STAT_ARMED_BIT = 8;
  localparam int STAT_MATCH_BIT = 9;
  localparam int STAT_TRIG_BIT = 10;

  // ==========================================================================
  // reset values and bus codes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ==========================================================================
  // capture sequencer, gray along idle -> wait -> store
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT_TRIG = 2'h1,
    ST_STORE = 2'h3
  } capture_state_e;

endpackage : trace_cmp_pkg

// ### rtl/cmp_c_if.sv
// Purpose: carries the comparator c operands and its hit result
// Assumes: all signals on the system clock
// Notes: cfg side drives operands, cmp side answers with hit

`timescale 1ns/1ps

interface cmp_c_if;
  logic [15:0] value;
  logic [7:0] page_ext;
  logic [15:0] addr;
  logic [7:0] page;
  logic hit;

  modport cfg (output value, output page_ext, output addr, output page,
               input hit);
  modport cmp (input value, input page_ext, input addr, input page,
               output hit);
endinterface : cmp_c_if

// ### rtl/cmp_c_match.sv
// Purpose: address comparator c with optional program-page extension
// Assumes: page index forms extended address bits 21:14
// Notes: purely combinational, the caller registers the result

`timescale 1ns/1ps

module cmp_c_match (
  // operands and result
  cmp_c_if.cmp cif
);

  logic paged;

  // ==========================================================================
  // compare
  always_comb begin
    // only the low bit of the paging selector counts
    paged = cif.page_ext[trace_cmp_pkg::PAGING_TYPE_SELECT_PAGED_BIT]; // see R9
    if (paged) begin
      // extended bits 21:16 from page bits 7:2, value bits 15:14 from page bits 1:0
      cif.hit = (cif.page_ext[trace_cmp_pkg::EXT_CMP_MSB:0]
                 == cif.page[7:2])
                && (cif.value[15:14] == cif.page[1:0])
                && (cif.value[13:0] == cif.addr[13:0]); // see R11
    end else begin
      cif.hit = (cif.value == cif.addr); // see R10
    end
  end

endmodule : cmp_c_match

// ### rtl/trace_count_compare_c.sv
// Purpose: trace buffer occupancy counter and third address comparator
// Assumes: ahb-lite single word transfers, trace events on the same clock
// Notes: reads take one wait state, writes none
//
// The AHB-Lite interface to the registers was left to the implementer.

`timescale 1ns/1ps

// Contract
// R1: set the full flag once 64 or more words were stored since arming.
// R2: while full is set, all 64 entries count as valid whatever the count.
// R3: writing one to arm clears the whole count register, count and full.
// R4: the 6-bit count gives valid words from 0 to 63 while full is clear.
// R5: a count wrap to zero sets full; in end-trigger mode counting goes on.
// R6: full with count zero in begin mode disarms, and breaks if enabled.
// R7: full with a nonzero count means 64 valid words, oldest overwritten.
// R8: the 2-bit paging selector picks the paged compare in both modes.
// R9: the top paging selector bit is ignored, so 10 and 11 act as 00, 01.
// R10: each comparator value bit says whether its address bit is 1 or 0.
// R11: with paging, extended bits 21:16 and 15:14 join the compare.
// R12: arming in loop-filter capture mode clears the comparator value.
// R13: software should keep the upper two extended compare bits at 00.
// R14: comparator c stays usable for breakpoints, with its own paging; the code blocks its break in loop-filter capture mode.
// R15: the trigger-position bit picks end (0) or begin (1) of storage.
// R16: the break-on-completion bit decides if a finished session breaks.
// R17: the count grows by exactly one for each word stored while capturing.
module trace_count_compare_c #(
  parameter int TRACE_DEPTH = 64
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu core side
  input wire logic [15:0] cpu_address_bus,
  input wire logic [7:0] program_page_index,
  // trace capture side
  input wire logic trace_word_stored,
  input wire logic trace_trigger,
  // debug results
  output logic break_request,
  output logic compare_c_match,
  output logic [$clog2(TRACE_DEPTH):0] valid_entries
);

  localparam int CNT_W = $clog2(TRACE_DEPTH);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(TRACE_DEPTH - 1);
  localparam logic [CNT_W:0] VALID_FULL = (CNT_W + 1)'(TRACE_DEPTH);
  localparam int RD_PAD = 32 - 8;

  // ==========================================================================
  // bus state
  logic rd_pend_r, rd_pend_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic addr_ok_r, addr_ok_nxt;
  logic [trace_cmp_pkg::IDX_W-1:0] idx_r, idx_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic [31:0] rd_word;
  logic accept;

  // ==========================================================================
  // core state
  trace_cmp_pkg::capture_state_e state_r, state_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] page_ext_r, page_ext_nxt;
  logic [7:0] val_hi_r, val_hi_nxt;
  logic [7:0] val_lo_r, val_lo_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt;
  logic trig_seen_r, trig_seen_nxt;
  logic brk_r, brk_nxt;
  logic match_r, match_nxt;
  logic [CNT_W:0] valid_r, valid_nxt;

  // ==========================================================================
  // decoded helpers
  logic wr_ctrl, wr_page, wr_hi, wr_lo, arm_wr, store_word;
  logic begin_en, brk_en, cmp_brk_en, loop_filter_capture_now;
  logic [1:0] capmod_wr;

  cmp_c_if cif ();

  assign cif.value = {val_hi_r, val_lo_r};
  assign cif.page_ext = page_ext_r;
  assign cif.addr = cpu_address_bus;
  assign cif.page = program_page_index;

  cmp_c_match u_cmp (
    .cif(cif)
  );

  assign accept = hsel && htrans[trace_cmp_pkg::HTRANS_ACTIVE_BIT] && hready;
  assign wr_ctrl = wr_pend_r && addr_ok_r && idx_r == trace_cmp_pkg::IDX_CTRL;
  assign wr_page = wr_pend_r && addr_ok_r
                   && idx_r == trace_cmp_pkg::IDX_PAGE_EXT;
  assign wr_hi = wr_pend_r && addr_ok_r && idx_r == trace_cmp_pkg::IDX_VAL_HI;
  assign wr_lo = wr_pend_r && addr_ok_r && idx_r == trace_cmp_pkg::IDX_VAL_LO;
  assign arm_wr = wr_ctrl && hwdata[trace_cmp_pkg::CTRL_ARM_BIT];
  assign capmod_wr = hwdata[trace_cmp_pkg::CAPMOD_MSB:
                            trace_cmp_pkg::CAPMOD_LSB];
  assign begin_en = ctrl_r[trace_cmp_pkg::CTRL_BEGIN_BIT];
  assign brk_en = ctrl_r[trace_cmp_pkg::CTRL_BRK_BIT];
  assign cmp_brk_en = ctrl_r[trace_cmp_pkg::CTRL_CMP_BRK_BIT];
  assign loop_filter_capture_now = ctrl_r[trace_cmp_pkg::CAPMOD_MSB:
                            trace_cmp_pkg::CAPMOD_LSB]
                     == trace_cmp_pkg::CAPMOD_LOOP_FILTER_CAPTURE;
  // a control write in the same cycle takes priority over a stored word
  assign store_word = state_r == trace_cmp_pkg::ST_STORE
                      && trace_word_stored && !wr_ctrl;

  // ==========================================================================
  // read mux, sampled in the wait cycle so a just-finished write is seen
  always_comb begin
    rd_word = '0;
    if (addr_ok_r) begin
      unique case (idx_r)
        trace_cmp_pkg::IDX_CTRL: begin
          rd_word = {RD_PAD'(0), ctrl_r};
          rd_word[trace_cmp_pkg::CTRL_ARM_BIT] =
            state_r != trace_cmp_pkg::ST_IDLE;
        end
        trace_cmp_pkg::IDX_STAT: begin
          rd_word[CNT_W:0] = valid_r;
          rd_word[trace_cmp_pkg::STAT_ARMED_BIT] =
            state_r != trace_cmp_pkg::ST_IDLE;
          rd_word[trace_cmp_pkg::STAT_MATCH_BIT] = match_r;
          rd_word[trace_cmp_pkg::STAT_TRIG_BIT] = trig_seen_r;
        end
        trace_cmp_pkg::IDX_COUNT: begin
          rd_word[CNT_W-1:0] = cnt_r; // see R4
          rd_word[trace_cmp_pkg::COUNT_FULL_BIT] = full_r;
        end
        trace_cmp_pkg::IDX_PAGE_EXT: rd_word = {RD_PAD'(0), page_ext_r};
        trace_cmp_pkg::IDX_VAL_HI: rd_word = {RD_PAD'(0), val_hi_r};
        trace_cmp_pkg::IDX_VAL_LO: rd_word = {RD_PAD'(0), val_lo_r};
        default: rd_word = '0;
      endcase
    end
  end

  // ==========================================================================
  // ahb-lite slave: next values
  always_comb begin
    rd_pend_nxt = 1'b0;
    wr_pend_nxt = 1'b0;
    addr_ok_nxt = addr_ok_r;
    idx_nxt = idx_r;
    hrdata_nxt = hrdata_r;
    hreadyout_nxt = 1'b1;
    if (rd_pend_r && !hreadyout_r) begin
      // wait cycle of a read: latch data, release next edge
      hrdata_nxt = rd_word;
    end else if (accept) begin
      idx_nxt = haddr[trace_cmp_pkg::IDX_LSB +: trace_cmp_pkg::IDX_W];
      addr_ok_nxt = haddr[31:trace_cmp_pkg::IDX_LSB + trace_cmp_pkg::IDX_W]
                    == '0 && haddr[trace_cmp_pkg::IDX_LSB-1:0] == '0;
      wr_pend_nxt = hwrite;
      rd_pend_nxt = !hwrite;
      hreadyout_nxt = hwrite;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      addr_ok_r <= 1'b0;
      idx_r <= '0;
      hrdata_r <= '0;
      hreadyout_r <= 1'b1;
    end else begin
      rd_pend_r <= rd_pend_nxt;
      wr_pend_r <= wr_pend_nxt;
      addr_ok_r <= addr_ok_nxt;
      idx_r <= idx_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= hreadyout_nxt;
    end
  end

  // ==========================================================================
  // capture sequencer, counter and configuration: next values
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    page_ext_nxt = page_ext_r;
    val_hi_nxt = val_hi_r;
    val_lo_nxt = val_lo_r;
    cnt_nxt = cnt_r;
    full_nxt = full_r;
    trig_seen_nxt = trig_seen_r;
    brk_nxt = 1'b0;
    // paging selector and extended bits are one software register
    if (wr_page) begin
      page_ext_nxt = hwdata[7:0]; // see R8
    end
    if (wr_hi) begin
      val_hi_nxt = hwdata[7:0];
    end
    if (wr_lo) begin
      val_lo_nxt = hwdata[7:0];
    end
    if (wr_ctrl) begin
      ctrl_nxt = hwdata[7:0] & trace_cmp_pkg::CTRL_STORE_MASK;
      if (arm_wr) begin
        cnt_nxt = '0; // see R3
        full_nxt = 1'b0; // see R3
        trig_seen_nxt = 1'b0;
        // begin mode waits for the trigger, end mode stores at once
        state_nxt = hwdata[trace_cmp_pkg::CTRL_BEGIN_BIT]
                    ? trace_cmp_pkg::ST_WAIT_TRIG
                    : trace_cmp_pkg::ST_STORE; // see R15
        if (capmod_wr == trace_cmp_pkg::CAPMOD_LOOP_FILTER_CAPTURE) begin
          val_hi_nxt = trace_cmp_pkg::REG_RST; // see R12
          val_lo_nxt = trace_cmp_pkg::REG_RST; // see R12
        end
      end else begin
        state_nxt = trace_cmp_pkg::ST_IDLE;
      end
    end else begin
      unique case (state_r)
        trace_cmp_pkg::ST_IDLE: begin
          state_nxt = trace_cmp_pkg::ST_IDLE;
        end
        trace_cmp_pkg::ST_WAIT_TRIG: begin
          if (trace_trigger) begin
            trig_seen_nxt = 1'b1;
            state_nxt = trace_cmp_pkg::ST_STORE;
          end
        end
        trace_cmp_pkg::ST_STORE: begin
          if (store_word) begin
            if (cnt_r == CNT_MAX) begin
              cnt_nxt = '0; // see R5
              full_nxt = 1'b1; // see R1
              if (begin_en) begin
                state_nxt = trace_cmp_pkg::ST_IDLE; // see R6
                brk_nxt = brk_en; // see R6
              end
            end else begin
              cnt_nxt = cnt_r + 1'b1; // see R17
            end
          end
          // in end mode the trigger closes the session
          if (!begin_en && trace_trigger) begin
            trig_seen_nxt = 1'b1;
            state_nxt = trace_cmp_pkg::ST_IDLE; // see R15
            brk_nxt = brk_en; // see R16
          end
        end
        default: state_nxt = trace_cmp_pkg::ST_IDLE;
      endcase
    end
    // comparator c breaks on its own, unavailable in loop-filter capture
    if (cmp_brk_en && cif.hit && !loop_filter_capture_now) begin
      brk_nxt = 1'b1; // see R14
    end
    match_nxt = cif.hit;
    // a wrapped buffer holds every entry, newest over oldest
    valid_nxt = full_nxt ? VALID_FULL : {1'b0, cnt_nxt}; // see R2 see R7
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= trace_cmp_pkg::ST_IDLE;
      ctrl_r <= trace_cmp_pkg::REG_RST;
      page_ext_r <= trace_cmp_pkg::REG_RST;
      val_hi_r <= trace_cmp_pkg::REG_RST;
      val_lo_r <= trace_cmp_pkg::REG_RST;
      cnt_r <= '0;
      full_r <= 1'b0;
      trig_seen_r <= 1'b0;
      brk_r <= 1'b0;
      match_r <= 1'b0;
      valid_r <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      page_ext_r <= page_ext_nxt;
      val_hi_r <= val_hi_nxt;
      val_lo_r <= val_lo_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      trig_seen_r <= trig_seen_nxt;
      brk_r <= brk_nxt;
      match_r <= match_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = trace_cmp_pkg::HRESP_OKAY;
  assign break_request = brk_r;
  assign compare_c_match = match_r;
  assign valid_entries = valid_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_full_on_wrap;
    store_word && cnt_r == CNT_MAX |=> full_r && cnt_r == '0;
  endproperty
  a_full_on_wrap: assert property (p_full_on_wrap) // see R1
    else $error("full flag not set on count wrap");

  property p_arm_clears;
    arm_wr |=> cnt_r == '0 && !full_r && valid_entries == '0;
  endproperty
  a_arm_clears: assert property (p_arm_clears) // see R3
    else $error("arm did not clear the count register");

  property p_full_valid;
    full_r |-> valid_entries == VALID_FULL;
  endproperty
  a_full_valid: assert property (p_full_valid) // see R2
    else $error("full buffer not reported as all valid");

  property p_count_valid;
    !full_r |-> valid_entries == {1'b0, cnt_r};
  endproperty
  a_count_valid: assert property (p_count_valid) // see R4
    else $error("valid entries disagree with word count");

  property p_inc_one;
    store_word && cnt_r != CNT_MAX |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_inc_one: assert property (p_inc_one) // see R17
    else $error("count did not step by one");

  property p_begin_done;
    store_word && cnt_r == CNT_MAX && begin_en
      |=> state_r == trace_cmp_pkg::ST_IDLE
          && (break_request || !$past(brk_en));
  endproperty
  a_begin_done: assert property (p_begin_done) // see R6
    else $error("begin mode did not disarm on full");

  property p_end_goes_on;
    store_word && cnt_r == CNT_MAX && !begin_en && !trace_trigger
      |=> state_r == trace_cmp_pkg::ST_STORE ##1
          (!$past(store_word) || cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_end_goes_on: assert property (p_end_goes_on) // see R5
    else $error("end mode stopped counting after wrap");

  property p_end_trigger;
    state_r == trace_cmp_pkg::ST_STORE && !begin_en && trace_trigger
      && !wr_ctrl && brk_en |=> state_r == trace_cmp_pkg::ST_IDLE
      && break_request;
  endproperty
  a_end_trigger: assert property (p_end_trigger) // see R16
    else $error("end trigger did not complete the session");

  property p_loop_filter_capture_clear;
    arm_wr && capmod_wr == trace_cmp_pkg::CAPMOD_LOOP_FILTER_CAPTURE
      |=> val_hi_r == trace_cmp_pkg::REG_RST
          && val_lo_r == trace_cmp_pkg::REG_RST;
  endproperty
  a_loop_filter_capture_clear: assert property (p_loop_filter_capture_clear) // see R12
    else $error("loop-filter arm left comparator value");

  property p_unpaged_cmp;
    !page_ext_r[trace_cmp_pkg::PAGING_TYPE_SELECT_PAGED_BIT]
      |=> compare_c_match == ($past(cpu_address_bus) == $past(cif.value));
  endproperty
  a_unpaged_cmp: assert property (p_unpaged_cmp) // see R9
    else $error("unpaged compare result wrong");

  property p_paged_cmp;
    page_ext_r[trace_cmp_pkg::PAGING_TYPE_SELECT_PAGED_BIT] && cif.hit
      |-> page_ext_r[trace_cmp_pkg::EXT_CMP_MSB:0]
          == program_page_index[7:2];
  endproperty
  a_paged_cmp: assert property (p_paged_cmp) // see R11
    else $error("paged hit without extended match");

  property p_cmp_brk;
    cmp_brk_en && cif.hit && !loop_filter_capture_now |=> break_request;
  endproperty
  a_cmp_brk: assert property (p_cmp_brk) // see R14
    else $error("comparator c hit did not break");

endmodule : trace_count_compare_c

// ### test/cpu_bus_model.sv
// Purpose: cpu core model driving the address bus and page index
// Assumes: the core changes both just after a rising edge
// Notes: the core owns the bus, so it is never released

`timescale 1ns/1ps

module cpu_bus_model (
  // system
  input wire logic clk,
  // core address outputs
  output logic [15:0] cpu_address_bus,
  output logic [7:0] program_page_index
);
  // ==========================================================================
  // address source
  initial begin
    cpu_address_bus = 16'hffff;
    program_page_index = 8'h00;
  end

  task automatic put(input logic [15:0] a, input logic [7:0] p);
    @(posedge clk);
    cpu_address_bus <= a;
    program_page_index <= p;
  endtask : put
endmodule : cpu_bus_model

// ### test/trace_count_and_compare_c_tb.sv
// Purpose: self-checking bench for the trace counter and comparator c
// Assumes: single ahb-lite slave, hready looped from hreadyout
// Notes: break pulses are counted by a monitor, not sampled by tests

`timescale 1ns/1ps

module trace_count_and_compare_c_tb;
  logic clk;
  logic sys_rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [15:0] cpu_address_bus;
  logic [7:0] program_page_index;
  logic trace_word_stored;
  logic trace_trigger;
  logic break_request;
  logic compare_c_match;
  logic [6:0] valid_entries;
  logic [31:0] rd;
  int fails;
  int samples_checked;
  int brk_cnt = 0;
  int b0;

  assign hready = hreadyout;

  trace_count_compare_c #(.TRACE_DEPTH(64)) dut (.clk(clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_address_bus(cpu_address_bus),
    .program_page_index(program_page_index),
    .trace_word_stored(trace_word_stored), .trace_trigger(trace_trigger),
    .break_request(break_request), .compare_c_match(compare_c_match),
    .valid_entries(valid_entries));

  cpu_bus_model cpu (.clk(clk), .cpu_address_bus(cpu_address_bus),
    .program_page_index(program_page_index));

  // ==========================================================================
  // clock, monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (break_request === 1'b1) begin
      brk_cnt <= brk_cnt + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  // ==========================================================================
  // tasks
  task automatic close_out;
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  // address phase held until hready, then data phase until hready again
  task automatic ahb_xfer(input logic wr, input logic [7:0] idx,
                          input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb_xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ahb_xfer(1'b1, idx, {24'hffffff, d});
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                        input string what);
    ahb_xfer(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic words(input int n);
    @(posedge clk);
    trace_word_stored <= 1'b1;
    repeat (n) @(posedge clk);
    trace_word_stored <= 1'b0;
    #1;
  endtask : words

  task automatic trig;
    @(posedge clk);
    trace_trigger <= 1'b1;
    @(posedge clk);
    trace_trigger <= 1'b0;
  endtask : trig

  task automatic probe(input logic [15:0] a, input logic [7:0] p,
                       input logic exp);
    cpu.put(a, p);
    repeat (2) @(posedge clk);
    #1;
    chk("compare_c_match", {31'h0, exp}, {31'h0, compare_c_match});
  endtask : probe

  // ==========================================================================
  // tests
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trace_word_stored = 1'b0;
    trace_trigger = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'(trace_cmp_pkg::IDX_COUNT + i), 32'h0, "reset value");
    end
    rd_chk(8'h00, 32'h0, "unmapped");
    for (int i = 1; i < 4; i++) begin
      wr(8'(trace_cmp_pkg::IDX_COUNT + i), 8'(8'ha0 + i));
      rd_chk(8'(trace_cmp_pkg::IDX_COUNT + i), 32'(8'ha0 + i), "rw reg");
    end
    wr(trace_cmp_pkg::IDX_COUNT, 8'hff);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h0, "count ro");
    // end-trigger session: fill, wrap, keep counting
    words(2);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h0, "count idle");
    wr(trace_cmp_pkg::IDX_CTRL, 8'h80);
    words(63);
    chk("valid_entries", 32'd63, {25'h0, valid_entries});
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h3f, "count 63");
    words(1);
    chk("valid_entries", 32'd64, {25'h0, valid_entries});
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h80, "count wrap");
    words(1);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h81, "count over");
    chk("valid_entries", 32'd64, {25'h0, valid_entries});
    wr(trace_cmp_pkg::IDX_CTRL, 8'h80);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h0, "count arm");
    chk("valid_entries", 32'd0, {25'h0, valid_entries});
    // begin-trigger session with break on completion
    wr(trace_cmp_pkg::IDX_CTRL, 8'h98);
    b0 = brk_cnt;
    words(3);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h0, "before trigger");
    trig();
    words(64);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h80, "begin full");
    chk("break count", b0 + 1, brk_cnt);
    ahb_xfer(1'b0, trace_cmp_pkg::IDX_STAT, 32'h0);
    chk("armed", 32'h0, {31'h0, rd[8]});
    words(2);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h80, "after disarm");
    // begin-trigger session without break
    wr(trace_cmp_pkg::IDX_CTRL, 8'h90);
    b0 = brk_cnt;
    trig();
    words(64);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h80, "quiet full");
    chk("break count", b0, brk_cnt);
    // end-trigger session stopped by the trigger
    wr(trace_cmp_pkg::IDX_CTRL, 8'h88);
    b0 = brk_cnt;
    words(5);
    trig();
    words(2);
    rd_chk(trace_cmp_pkg::IDX_COUNT, 32'h05, "end trigger");
    chk("break count", b0 + 1, brk_cnt);
    // loop-filter arming wipes the comparator value
    wr(trace_cmp_pkg::IDX_VAL_HI, 8'h12);
    wr(trace_cmp_pkg::IDX_VAL_LO, 8'h34);
    wr(trace_cmp_pkg::IDX_CTRL, 8'h81);
    rd_chk(trace_cmp_pkg::IDX_VAL_HI, 32'h0, "value hi");
    rd_chk(trace_cmp_pkg::IDX_VAL_LO, 32'h0, "value lo");
    wr(trace_cmp_pkg::IDX_CTRL, 8'h00);
    // plain 16-bit compare, every bit flipped once
    wr(trace_cmp_pkg::IDX_PAGE_EXT, 8'h00);
    wr(trace_cmp_pkg::IDX_VAL_HI, 8'h12);
    wr(trace_cmp_pkg::IDX_VAL_LO, 8'h34);
    probe(16'h1234, 8'h15, 1'b1);
    for (int b = 0; b < 16; b++) begin
      probe(16'h1234 ^ (16'h1 << b), 8'h00, 1'b0);
    end
    // paged compare over all four selector codes
    wr(trace_cmp_pkg::IDX_VAL_HI, 8'h52);
    for (int k = 0; k < 4; k++) begin
      wr(trace_cmp_pkg::IDX_PAGE_EXT, {2'(k), 6'h05});
      probe(16'h9234, 8'h15, 1'(k));
    end
    probe(16'h9234, 8'h11, 1'b0);
    probe(16'h9234, 8'h16, 1'b0);
    // comparator c as a breakpoint source
    wr(trace_cmp_pkg::IDX_CTRL, 8'h04);
    b0 = brk_cnt;
    probe(16'h9234, 8'h15, 1'b1);
    chk("break seen", 32'h1, {31'h0, brk_cnt > b0});
    probe(16'h0000, 8'h00, 1'b0);
    // loop-filter capture mode keeps comparator c from breaking
    wr(trace_cmp_pkg::IDX_CTRL, 8'h05);
    b0 = brk_cnt;
    probe(16'h9234, 8'h15, 1'b1);
    chk("loop_filter_capture break count", b0, brk_cnt);
    wr(trace_cmp_pkg::IDX_CTRL, 8'h00);
    close_out();
  end
endmodule : trace_count_and_compare_c_tb
